//--- src/indirect_regs_and_arb_id.sv
/*
  Indirect register front end: index register, data window, unit ID,
  version and arbitration ID, plus redirection entry storage.
  Assumes a host decoder that drives chip select, data/index select,
  write strobe and byte enables synchronous to clk_in, and a bus engine
  that reports arbitration outcomes as pulses.
*/
// Functional notes
// RL1: low chip select; select pin picks index/window
// RL2: byte write loads 8-bit index
// RL3: window access goes to indexed register
// RL4: host uses full 32-bit window accesses
// RL5: host does read-modify-write of whole word
// RL6: 64-bit entries are two 32-bit words
// RL7: map: ID 00, version 01, arb 02, entries 10-3F
// RL8: indexed register access attribute gates effect
// RL9: index holds offset in bits 7:0
// RL10: unit ID read/write in bits 27:24
// RL11: unit ID write also loads arbitration ID
// RL12: software sets unique ID before transmitting
// RL13: version bits 23:16 read max entry 17h
// RL14: version bits 7:0 read implementation code
// RL15: arbitration ID read-only, resets to zero
// RL16: rotating priority arbitration on the bus
// RL17: winner takes arbitration ID zero
// RL18: losers increment; ID 15 takes winner plus one
// RL19: update after success, lowpri always
// RL20: success means no checksum or acceptance error
// RL21: init-deassert reloads arbitration ID from unit ID
// RL22: low test input invokes test mode
// RL23: reset restores every default
// RL24: reserved and unmapped read zero, writes ignored
`timescale 1ns/1ns
module indirect_regs_and_arb_id
  import ixreg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // host access
  input  wire logic        chip_sel_n_in,
  input  wire logic        data_sel_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [3:0]  byte_en_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] rdata_out,
  // bus engine outcome
  input  wire logic        msg_done_in,
  input  wire logic        msg_won_in,
  input  wire logic        msg_lowpri_in,
  input  wire logic        cksum_err_in,
  input  wire logic        accept_err_in,
  input  wire logic [3:0]  winner_id_in,
  input  wire logic        init_deassert_in,
  // status and test
  input  wire logic        test_mode_in_n,
  output logic      [3:0]  unit_id_out,
  output logic      [3:0]  arb_id_out,
  output logic             test_mode_out
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  logic        sel;
  logic        idx_wr;
  logic        win_wr;
  logic        win_full;
  logic        hit_id;
  logic        hit_ver;
  logic        hit_arb;
  logic        hit_red;
  logic [7:0]  red_off;
  logic [5:0]  red_word;
  logic [31:0] red_rdata;

  logic [7:0]  index_q;
  logic [7:0]  index_d;
  logic [3:0]  unit_id_q;
  logic [3:0]  unit_id_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        test_q;
  logic        test_d;

  arb_update_if upd ();

  always_comb begin
    sel      = !chip_sel_n_in; // RL1
    idx_wr   = sel && !data_sel_in && wr_in && byte_en_in[0]; // RL1 RL2
    // narrow window writes could corrupt fields, so they are dropped
    win_full = (byte_en_in == 4'hf); // RL4
    win_wr   = sel && data_sel_in && wr_in && win_full; // RL3
    hit_id   = (index_q == IDX_UNIT_ID); // RL7
    hit_ver  = (index_q == IDX_VERSION); // RL7
    hit_arb  = (index_q == IDX_ARB_ID); // RL7
    hit_red  = (index_q >= IDX_RED_LO) && (index_q <= IDX_RED_HI); // RL7
    red_off  = 8'(index_q - IDX_RED_LO);
    red_word = red_off[5:0]; // RL6
  end

  // ----------------------------------------------------------------------
  // index and unit id registers
  // ----------------------------------------------------------------------
  always_comb begin
    index_d   = index_q;
    unit_id_d = unit_id_q;
    if (idx_wr) begin
      index_d = wdata_in[7:0]; // RL2 RL9
    end
    // only the id register is writable among the fixed ones
    if (win_wr && hit_id) begin
      unit_id_d = wdata_in[ID_MSB:ID_LSB]; // RL8 RL10
    end
    if (srst_in) begin
      index_d   = INDEX_RESET; // RL23
      unit_id_d = UNIT_ID_RESET; // RL23
    end
  end

  always_ff @(posedge clk_in) begin
    index_q   <= index_d;
    unit_id_q <= unit_id_d;
  end

  assign upd.id_load  = win_wr && hit_id; // RL11
  assign upd.id_value = wdata_in[ID_MSB:ID_LSB];

  // ----------------------------------------------------------------------
  // redirection storage and arbitration tracker
  // ----------------------------------------------------------------------
  redir_store u_redir (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (win_wr && hit_red), // RL8
    .waddr_in  (red_word),
    .wdata_in  (wdata_in),
    .raddr_in  (red_word),
    .rdata_out (red_rdata)
  );

  arb_id_tracker u_arb (
    .clk_in           (clk_in),
    .srst_in          (srst_in),
    .msg_done_in      (msg_done_in),
    .msg_won_in       (msg_won_in),
    .msg_lowpri_in    (msg_lowpri_in),
    .cksum_err_in     (cksum_err_in),
    .accept_err_in    (accept_err_in),
    .winner_id_in     (winner_id_in),
    .init_deassert_in (init_deassert_in),
    .unit_id_in       (unit_id_q),
    .upd              (upd.track)
  );

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    if (sel && rd_in) begin
      rdata_d = 32'h0000_0000; // RL24
      if (!data_sel_in) begin
        rdata_d[7:0] = index_q; // RL9
      end else if (hit_id) begin
        rdata_d[ID_MSB:ID_LSB] = unit_id_q; // RL10
      end else if (hit_ver) begin
        rdata_d[MAXENT_MSB:MAXENT_LSB] = MAX_ENTRY; // RL13
        rdata_d[VER_MSB:VER_LSB]       = IMPL_VERSION; // RL14
      end else if (hit_arb) begin
        rdata_d[ID_MSB:ID_LSB] = upd.arb_id; // RL15
      end else if (hit_red) begin
        rdata_d = red_rdata; // RL3
      end
    end
    if (srst_in) begin
      rdata_d = 32'h0000_0000; // RL23
    end
  end

  // test pin taken as a plain synchronous level
  always_comb begin
    test_d = !test_mode_in_n; // RL22
    if (srst_in) begin
      test_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_q <= rdata_d;
    test_q  <= test_d;
  end

  assign rdata_out     = rdata_q;
  assign unit_id_out   = unit_id_q;
  assign arb_id_out    = upd.arb_id;
  assign test_mode_out = test_q;

endmodule

//--- src/ixreg_pkg.sv
/*
  Constants for the indirect register front end: index map, field layout,
  reset values and arbitration figures.
  Assumes nothing of its surroundings.
*/
package ixreg_pkg;

  // ----------------------------------------------------------------------
  // index map
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_UNIT_ID  = 8'h00;
  localparam logic [7:0] IDX_VERSION  = 8'h01;
  localparam logic [7:0] IDX_ARB_ID   = 8'h02;
  localparam logic [7:0] IDX_RED_LO   = 8'h10;
  localparam logic [7:0] IDX_RED_HI   = 8'h3f;
  localparam int         RED_ENTRIES  = 24;
  localparam int         RED_WORDS    = 48;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int ID_LSB     = 24;
  localparam int ID_MSB     = 27;
  localparam int MAXENT_LSB = 16;
  localparam int MAXENT_MSB = 23;
  localparam int VER_LSB    = 0;
  localparam int VER_MSB    = 7;

  // ----------------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  INDEX_RESET   = 8'h00;
  localparam logic [3:0]  UNIT_ID_RESET = 4'h0;
  localparam logic [3:0]  ARB_ID_RESET  = 4'h0;
  localparam logic [31:0] RED_RESET     = 32'h0000_0000;
  localparam logic [7:0]  MAX_ENTRY     = 8'h17;
  // arbitrary implementation code, not tied to any real part
  localparam logic [7:0]  IMPL_VERSION  = 8'h5a;

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  localparam logic [3:0] ARB_ID_TOP    = 4'hf;
  localparam logic [3:0] ARB_ID_WINNER = 4'h0;

  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_WAIT = 2'b01
  } arb_state_type;

endpackage

//--- src/arb_update_if.sv
/*
  Carrier between the register front end and the arbitration tracker.
  Assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
interface arb_update_if;
  logic       id_load;
  logic [3:0] id_value;
  logic [3:0] arb_id;
  modport front (output id_load, output id_value, input arb_id);
  modport track (input id_load, input id_value, output arb_id);
endinterface

//--- src/arb_id_tracker.sv
/*
  Rotating arbitration ID of the unit on the serial interrupt bus.
  Assumes the bus engine reports each arbitration outcome as one-cycle pulses.
*/
`timescale 1ns/1ns
module arb_id_tracker
  import ixreg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // bus engine outcome
  input  wire logic       msg_done_in,
  input  wire logic       msg_won_in,
  input  wire logic       msg_lowpri_in,
  input  wire logic       cksum_err_in,
  input  wire logic       accept_err_in,
  input  wire logic [3:0] winner_id_in,
  input  wire logic       init_deassert_in,
  input  wire logic [3:0] unit_id_in,
  // front end
  arb_update_if.track     upd
);

  // ----------------------------------------------------------------------
  // next arbitration id
  // ----------------------------------------------------------------------
  logic [3:0] arb_q;
  logic [3:0] arb_d;
  logic       success;
  logic       rotate;

  assign upd.arb_id = arb_q;

  always_comb begin
    success = !cksum_err_in && !accept_err_in; // RL20
    rotate  = msg_done_in && (success || msg_lowpri_in); // RL19
    arb_d   = arb_q;
    if (rotate) begin
      // RL16
      if (msg_won_in) begin
        arb_d = ARB_ID_WINNER; // RL17
      end else if (arb_q == ARB_ID_TOP) begin
        arb_d = 4'(winner_id_in + 4'h1); // RL18
      end else begin
        arb_d = 4'(arb_q + 4'h1); // RL18
      end
    end
    // id write and init-deassert override a same-cycle rotation
    if (init_deassert_in) begin
      arb_d = unit_id_in; // RL21
    end
    if (upd.id_load) begin
      arb_d = upd.id_value; // RL11
    end
    if (srst_in) begin
      arb_d = ARB_ID_RESET; // RL15
    end
  end

  always_ff @(posedge clk_in) begin
    arb_q <= arb_d;
  end

endmodule

//--- src/redir_store.sv
/*
  Storage for the redirection entries, each 64-bit entry as two
  independent 32-bit words. No field behaviour is modelled anywhere.
  Assumes word index 0 is the low half of entry 0.
*/
`timescale 1ns/1ns
module redir_store
  import ixreg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // word access
  input  wire logic        wr_in,
  input  wire logic [5:0]  waddr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic [5:0]  raddr_in,
  output logic      [31:0] rdata_out
);

  // ----------------------------------------------------------------------
  // word array
  // ----------------------------------------------------------------------
  logic [31:0] mem_q [RED_WORDS];
  logic [31:0] mem_d [RED_WORDS];

  always_comb begin
    for (int i = 0; i < RED_WORDS; i++) begin
      mem_d[i] = mem_q[i];
      if (srst_in) begin
        mem_d[i] = RED_RESET;
      end else if (wr_in && (waddr_in == 6'(i))) begin
        mem_d[i] = wdata_in; // RL6
      end
    end
  end

  always_ff @(posedge clk_in) begin
    mem_q <= mem_d;
  end

  assign rdata_out = (raddr_in < 6'(RED_WORDS)) ? mem_q[raddr_in] : 32'h0000_0000;

endmodule

//--- tb/indirect_regs_assertions.sv
/*
  Port checks for the indirect register front end.
  Assumes one clock and a synchronous active-high reset; bound by the bench.
*/
`timescale 1ns/1ns
module indirect_regs_assertions
  import ixreg_pkg::*;
(
  // clock and reset
  input wire logic        clk_in,
  input wire logic        srst_in,
  // host access
  input wire logic        chip_sel_n_in,
  input wire logic        data_sel_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [3:0]  byte_en_in,
  input wire logic [31:0] wdata_in,
  input wire logic [31:0] rdata_out,
  // bus engine
  input wire logic        msg_done_in,
  input wire logic        msg_won_in,
  input wire logic        msg_lowpri_in,
  input wire logic        cksum_err_in,
  input wire logic        accept_err_in,
  input wire logic [3:0]  winner_id_in,
  input wire logic        init_deassert_in,
  // status and test
  input wire logic        test_mode_in_n,
  input wire logic [3:0]  unit_id_out,
  input wire logic [3:0]  arb_id_out,
  input wire logic        test_mode_out
);
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic       id_wr;
  logic       rot;
  // ------------------------------------------------------------------
  // index shadow: the real one is out of sight
  // ------------------------------------------------------------------
  always_comb begin
    idx_d = idx_q;
    if (!chip_sel_n_in && !data_sel_in && wr_in && byte_en_in[0]) begin
      idx_d = wdata_in[7:0];
    end
  end
  always_ff @(posedge clk_in) begin
    idx_q <= srst_in ? INDEX_RESET : idx_d;
  end
  assign id_wr = !chip_sel_n_in && data_sel_in && wr_in && byte_en_in == 4'hf
                 && idx_q == IDX_UNIT_ID;
  assign rot   = msg_done_in && (msg_lowpri_in || !(cksum_err_in || accept_err_in))
                 && !id_wr && !init_deassert_in;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  rst_values_a: assert property (disable iff (1'b0) srst_in |=>
    rdata_out == 32'h0 && unit_id_out == 4'h0 && arb_id_out == 4'h0 && !test_mode_out)
    else $error("outputs off default after reset");
  id_write_a: assert property (id_wr |=>
    unit_id_out == $past(wdata_in[27:24]) && arb_id_out == unit_id_out)
    else $error("id write not taken by both ids");
  ver_read_a: assert property (!chip_sel_n_in && data_sel_in && rd_in
    && idx_q == IDX_VERSION |=> rdata_out == {8'h00, MAX_ENTRY, 8'h00, IMPL_VERSION})
    else $error("version read wrong");
  win_zero_a: assert property (rot && msg_won_in |=> arb_id_out == ARB_ID_WINNER)
    else $error("winner id not zero");
  lose_inc_a: assert property (rot && !msg_won_in && arb_id_out != ARB_ID_TOP
    |=> arb_id_out == $past(arb_id_out) + 4'h1)
    else $error("loser id did not step");
  top_wrap_a: assert property (rot && !msg_won_in && arb_id_out == ARB_ID_TOP
    |=> arb_id_out == $past(winner_id_in) + 4'h1)
    else $error("top id did not follow winner");
  fail_hold_a: assert property (msg_done_in && !msg_lowpri_in
    && (cksum_err_in || accept_err_in) && !id_wr && !init_deassert_in |=> $stable(arb_id_out))
    else $error("failed message moved id");
  init_load_a: assert property (init_deassert_in && !id_wr
    |=> arb_id_out == $past(unit_id_out))
    else $error("init did not reload id");
  test_mode_a: assert property (1'b1 |=> test_mode_out == !$past(test_mode_in_n))
    else $error("test mode output wrong");
endmodule

//--- tb/host_decoder_model.sv
/*
  Host decoder model: chip select, data/index select, strobes, data.
  Assumes each task is entered just after a rising edge of clk_in.
*/
`timescale 1ns/1ns
module host_decoder_model (
  // clock
  input  wire logic   clk_in,
  // decoded access
  output logic        cs_n_out,
  output logic        ds_out,
  output logic        wr_out,
  output logic        rd_out,
  output logic [3:0]  be_out,
  output logic [31:0] wdata_out
);
  initial begin
    cs_n_out = 1'b1;
    ds_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    be_out = 4'h0;
    wdata_out = 32'h0;
  end
  // held until the edge that takes it
  task automatic access(input logic ds, input logic wr, input logic [3:0] be,
                        input logic [31:0] d);
    cs_n_out <= 1'b0;
    ds_out <= ds;
    wr_out <= wr;
    rd_out <= !wr;
    be_out <= be;
    wdata_out <= d;
    @(posedge clk_in);
  endtask
  // released data line shows a changing pattern, not the last value
  task automatic idle();
    cs_n_out <= 1'b1;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~wdata_out;
    @(posedge clk_in);
  endtask
endmodule

//--- tb/tb_indirect_regs_and_arb_id.sv
/*
  Self-checking bench for the indirect register front end.
  Assumes the host model and the port checker beside it in tb/.
*/
`timescale 1ns/1ns
`define check(got, exp) cmp(32'(got), 32'(exp))
module tb_indirect_regs_and_arb_id
  import ixreg_pkg::*;
;
  localparam logic [31:0] VER = {8'h00, MAX_ENTRY, 8'h00, IMPL_VERSION};
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        cs_n, ds, wr, rd, rd_pend = 1'b0;
  logic [3:0]  be, unit_id, arb_id;
  logic [31:0] wdata, rdata;
  logic [5:0]  ev = 6'h0;  // won, lowpri, cksum, accept, init, done
  logic [3:0]  winner = 4'h0;
  logic        test_n = 1'b1;
  logic        test_mode;
  logic [31:0] rnd = 32'hb5f6;
  logic [31:0] red [48];
  logic [31:0] expq [$];
  logic [7:0]  ro [6] = '{8'h01, 8'h02, 8'h03, 8'h0f, 8'h40, 8'hff};
  int          mismatches = 0;
  int          samples_checked = 0;
  always #5 clk_in = ~clk_in;
  host_decoder_model i_host (.clk_in, .cs_n_out(cs_n), .ds_out(ds), .wr_out(wr), .rd_out(rd),
    .be_out(be), .wdata_out(wdata));
  indirect_regs_and_arb_id i_dut (.clk_in, .srst_in, .chip_sel_n_in(cs_n), .data_sel_in(ds),
    .wr_in(wr), .rd_in(rd), .byte_en_in(be), .wdata_in(wdata), .rdata_out(rdata),
    .msg_done_in(ev[0]), .msg_won_in(ev[5]), .msg_lowpri_in(ev[4]), .cksum_err_in(ev[3]),
    .accept_err_in(ev[2]), .winner_id_in(winner), .init_deassert_in(ev[1]),
    .test_mode_in_n(test_n), .unit_id_out(unit_id), .arb_id_out(arb_id),
    .test_mode_out(test_mode));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] b);
    i_host.access(1'b0, 1'b1, 4'h1, {d[31:8], idx});
    i_host.access(1'b1, 1'b1, b, d);
    i_host.idle();
  endtask
  task automatic get(input logic [7:0] idx, input logic [31:0] e);
    i_host.access(1'b0, 1'b1, 4'h1, {rnd[31:8], idx});
    expq.push_back(e);
    i_host.access(1'b1, 1'b0, 4'hf, rnd);
    i_host.idle();
  endtask
  task automatic arb(input logic [5:0] f, input logic [3:0] w, input logic [3:0] e);
    ev <= f;
    winner <= w;
    @(posedge clk_in);
    ev <= 6'h0;
    winner <= ~w;
    @(posedge clk_in);
    `check(arb_id, e);
  endtask
  // read data lands one cycle after the taking edge
  always @(posedge clk_in) begin
    if (rd_pend && expq.size() > 0) begin
      `check(rdata, expq.pop_front());
    end
    rd_pend <= !cs_n && rd && !srst_in;
  end
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    get(IDX_UNIT_ID, 32'h0);
    get(IDX_VERSION, VER);
    get(IDX_ARB_ID, 32'h0);
    foreach (ro[i]) begin
      rnd = xs(rnd);
      put(ro[i], rnd, 4'hf);
      get(ro[i], (ro[i] == IDX_VERSION) ? VER : 32'h0);
    end
    i_host.access(1'b0, 1'b1, 4'h1, 32'hffff_ff3c);
    i_host.access(1'b0, 1'b1, 4'he, 32'h0000_0055);
    expq.push_back(32'h0000_003c);
    i_host.access(1'b0, 1'b0, 4'h1, 32'h0);
    i_host.idle();
    $display("defaults, read-only and unmapped places done");
    for (int w = 0; w < RED_WORDS; w++) begin
      rnd = xs(rnd);
      red[w] = rnd;
      put(IDX_RED_LO + 8'(w), rnd, 4'hf);
    end
    put(IDX_RED_LO, ~red[0], 4'h3);
    for (int w = 0; w < RED_WORDS; w++) begin
      get(IDX_RED_LO + 8'(w), red[w]);
    end
    // field change as read, modify, write back of the whole word
    get(IDX_RED_LO + 8'h1, red[1]);
    put(IDX_RED_LO + 8'h1, {rdata[31:8], 8'ha5}, 4'hf);
    get(IDX_RED_LO + 8'h1, {red[1][31:8], 8'ha5});
    $display("redirection words done");
    rnd = xs(rnd);
    put(IDX_UNIT_ID, rnd, 4'hf);
    get(IDX_UNIT_ID, rnd & 32'h0f00_0000);
    get(IDX_ARB_ID, rnd & 32'h0f00_0000);
    `check(unit_id, rnd[27:24]);
    put(IDX_UNIT_ID, 32'h0300_0000, 4'hf);
    arb(6'h01, 4'h9, 4'h4);
    arb(6'h09, 4'h9, 4'h4);
    arb(6'h05, 4'h9, 4'h4);
    arb(6'h19, 4'h9, 4'h5);
    arb(6'h21, 4'h9, 4'h0);
    arb(6'h02, 4'h9, 4'h3);
    put(IDX_UNIT_ID, 32'h0f00_0000, 4'hf);
    arb(6'h01, 4'h6, 4'h7);
    // id write meets init and a rotation in one cycle: the write wins
    i_host.access(1'b0, 1'b1, 4'h1, 32'h0);
    ev <= 6'h03;
    i_host.access(1'b1, 1'b1, 4'hf, 32'h0200_0000);
    ev <= 6'h00;
    i_host.idle();
    `check(arb_id, 4'h2);
    $display("arbitration rotation done");
    test_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    `check(test_mode, 1'b1);
    test_n <= 1'b1;
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    // index itself must be back at its default
    expq.push_back(32'h0);
    i_host.access(1'b0, 1'b0, 4'h1, 32'h0);
    i_host.idle();
    get(IDX_UNIT_ID, 32'h0);
    get(IDX_ARB_ID, 32'h0);
    get(IDX_RED_HI, 32'h0);
    $display("test input and second reset done");
    repeat (3) @(posedge clk_in);
    wrap_up();
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    wrap_up();
  end
endmodule
bind indirect_regs_and_arb_id indirect_regs_assertions i_chk (.clk_in, .srst_in, .chip_sel_n_in,
  .data_sel_in, .wr_in, .rd_in, .byte_en_in, .wdata_in, .rdata_out, .msg_done_in, .msg_won_in,
  .msg_lowpri_in, .cksum_err_in, .accept_err_in, .winner_id_in, .init_deassert_in,
  .test_mode_in_n, .unit_id_out, .arb_id_out, .test_mode_out);
